// ### verilog/blc_pkg.sv
package blc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_BRT_CTRL   = 8'h11;
  localparam logic [7:0] ADDR_PWM_CTRL   = 8'h12;
  localparam logic [7:0] ADDR_BOOST_CTRL = 8'h13;
  localparam logic [7:0] ADDR_AF_HI      = 8'h15;
  localparam logic [7:0] ADDR_AF_LO      = 8'h16;
  localparam logic [7:0] ADDR_CODE_LO    = 8'h18;
  localparam logic [7:0] ADDR_CODE_HI    = 8'h19;
  localparam logic [7:0] ADDR_FAULT_POL  = 8'h1e;
  localparam logic [7:0] ADDR_FAULT_IND  = 8'h1f;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BRT_MAP_BIT   = 7;
  localparam int BRT_SRC_LSB   = 5;
  localparam int BRT_RAMP_BIT  = 4;
  localparam int BRT_RATE_LSB  = 1;
  localparam int PWM_RATE_LSB  = 6;
  localparam int PWM_POL_BIT   = 5;
  localparam int PWM_HYST_LSB  = 2;
  localparam int PWM_FILT_LSB  = 0;
  localparam int BST_SHIFT_BIT = 6;
  localparam int BST_FREQ_BIT  = 5;
  localparam int BST_IND_BIT   = 4;
  localparam int BST_OVP_LSB   = 2;
  localparam int BST_OCP_LSB   = 0;
  localparam int POL_SHORT_EN  = 3;
  localparam int POL_THERM_BIT = 2;
  localparam int POL_OCP_BIT   = 1;
  localparam int POL_OVP_BIT   = 0;
  localparam int FLAG_OPEN     = 4;
  localparam int FLAG_SHORT    = 3;
  localparam int FLAG_THERM    = 2;
  localparam int FLAG_OCP      = 1;
  localparam int FLAG_OVP      = 0;

  // ----------------------------------------------------------------
  // Reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BRT_CTRL   = 8'h60;
  localparam logic [7:0] RST_PWM_CTRL   = 8'hf3;
  localparam logic [7:0] RST_BOOST_CTRL = 8'h6f;
  localparam logic [7:0] RST_AF         = 8'h00;
  localparam logic [2:0] RST_CODE_LO    = 3'h7;
  localparam logic [7:0] RST_CODE_HI    = 8'hff;
  localparam logic [3:0] RST_FAULT_POL  = 4'h7;
  localparam logic [7:0] BRT_WMASK      = 8'hfe;
  localparam logic [7:0] BOOST_WMASK    = 8'h7f;
  localparam logic [2:0] HYST_INVALID   = 3'h7;
  localparam logic [2:0] HYST_RST       = 3'h4;
  localparam logic [1:0] SRC_REG        = 2'h0;
  localparam logic [1:0] SRC_PWM        = 2'h1;
  localparam logic [1:0] SRC_MUL_RAMP   = 2'h2;
  localparam logic [1:0] SRC_RAMP_MUL   = 2'h3;
  localparam logic [1:0] AF_250K        = 2'h0;
  localparam logic [1:0] AF_500K        = 2'h1;
  localparam logic [1:0] AF_1M          = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int  CLK_HZ        = 50_000_000;
  localparam int  CLK_MHZ       = 50;
  localparam int  SMP_800K_HZ   = 800_000;
  localparam int  SMP_4M_HZ     = 4_000_000;
  localparam int  SMP_24M_HZ    = 24_000_000;
  localparam int  SMP_800K_CYC  = CLK_HZ / SMP_800K_HZ;
  localparam int  SMP_4M_CYC    = CLK_HZ / SMP_4M_HZ;
  localparam int  SMP_24M_CYC   = CLK_HZ / SMP_24M_HZ;
  localparam int  FILT_100_NS   = 100;
  localparam int  FILT_150_NS   = 150;
  localparam int  FILT_200_NS   = 200;
  localparam int  FILT_100_CYC  = (FILT_100_NS * CLK_MHZ + 999) / 1000;
  localparam int  FILT_150_CYC  = (FILT_150_NS * CLK_MHZ + 999) / 1000;
  localparam int  FILT_200_CYC  = (FILT_200_NS * CLK_MHZ + 999) / 1000;
  localparam real RAMP_BASE_MS  = 0.125;
  localparam int  RAMP_BASE_CYC = int'(RAMP_BASE_MS * CLK_HZ / 1000.0);
  localparam logic [10:0] DUTY_WIN_LAST = 11'h7ff;

  // ----------------------------------------------------------------
  // Shutdown states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SD_RUN       = 2'b00,
    SD_WAIT_READ = 2'b01,
    SD_READY     = 2'b11
  } blc_sd_t;

endpackage

// ### verilog/blc_pwm_sense.sv
module blc_pwm_sense
  import blc_pkg::*;
(
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_clk_en,
  // PWM pin and conditioning
  input  wire logic        i_pwm_pin,
  input  wire logic [1:0]  i_rate_sel,
  input  wire logic        i_pol_high,
  input  wire logic [1:0]  i_filt_sel,
  // Measured duty
  output logic      [10:0] o_duty,
  output logic             o_duty_valid
);

  typedef struct packed {
    logic [2:0]  sync;
    logic        lvl;
    logic [3:0]  fcnt;
    logic [5:0]  scnt;
    logic [10:0] win;
    logic [11:0] high;
    logic [10:0] duty;
    logic        valid;
  } blc_sense_t;

  localparam blc_sense_t SENSE_RST = '0;

  blc_sense_t st_r;
  blc_sense_t st_nxt;
  logic       active;
  logic [11:0] sum;

  function automatic logic [5:0] smp_period(input logic [1:0] sel);
    case (sel)
      2'b00:   smp_period = 6'(SMP_800K_CYC);
      2'b01:   smp_period = 6'(SMP_4M_CYC);
      default: smp_period = 6'(SMP_24M_CYC);
    endcase
  endfunction

  function automatic logic [3:0] filt_need(input logic [1:0] sel);
    case (sel)
      2'b00:   filt_need = 4'h0;
      2'b01:   filt_need = 4'(FILT_100_CYC);
      2'b10:   filt_need = 4'(FILT_150_CYC);
      default: filt_need = 4'(FILT_200_CYC);
    endcase
  endfunction

  always_comb begin
    st_nxt       = st_r;
    st_nxt.valid = 1'b0;
    sum          = 12'h000;
    st_nxt.sync  = {st_r.sync[1:0], i_pwm_pin};
    // Glitch filter: new level must hold for the selected time
    if ((st_r.sync[2] == st_r.sync[1]) && (st_r.sync[2] != st_r.lvl)) begin
      if ((st_r.fcnt + 4'h1) >= filt_need(i_filt_sel)) begin
        st_nxt.lvl  = st_r.sync[2];
        st_nxt.fcnt = 4'h0;
      end else begin
        st_nxt.fcnt = st_r.fcnt + 4'h1;
      end
    end else begin
      st_nxt.fcnt = 4'h0;
    end
    active = i_pol_high ? st_r.lvl : ~st_r.lvl;
    // Duty is the share of active samples over a 2048-sample window
    if (st_r.scnt >= (smp_period(i_rate_sel) - 6'h1)) begin
      st_nxt.scnt = 6'h00;
      if (st_r.win == DUTY_WIN_LAST) begin
        sum          = st_r.high + {11'h000, active};
        st_nxt.duty  = sum[11] ? 11'h7ff : sum[10:0];
        st_nxt.valid = 1'b1;
        st_nxt.high  = 12'h000;
        st_nxt.win   = 11'h000;
      end else begin
        st_nxt.win  = st_r.win + 11'h001;
        st_nxt.high = st_r.high + {11'h000, active};
      end
    end else begin
      st_nxt.scnt = st_r.scnt + 6'h01;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      st_r <= SENSE_RST;
    end else if (i_clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign o_duty       = st_r.duty;
  assign o_duty_valid = st_r.valid;

endmodule

// ### verilog/blc_reg_bank.sv
module blc_reg_bank
  import blc_pkg::*;
#(
  parameter int P_RAMP_BASE_CYC = RAMP_BASE_CYC
)
(
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_clk_en,
  // Register port
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  output logic             o_reg_rvalid,
  // PWM pin and device enable
  input  wire logic        i_pwm_pin,
  input  wire logic        i_dev_enable,
  // Fault monitors
  input  wire logic        i_string_open,
  input  wire logic        i_string_short,
  input  wire logic        i_thermal_trip,
  input  wire logic        i_switch_current_limit,
  input  wire logic        i_output_overvoltage_guard,
  // Analog controls
  output logic      [10:0] o_led_code,
  output logic             o_boost_freq_1m,
  output logic             o_boost_no_shift,
  output logic             o_inductor_10u,
  output logic      [1:0]  o_output_overvoltage_guard_sel,
  output logic      [1:0]  o_switch_current_limit_sel,
  output logic      [1:0]  o_autofreq_sel,
  output logic             o_short_detect_on,
  output logic             o_device_on
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  brt_ctrl;
    logic [7:0]  pwm_ctrl;
    logic [7:0]  boost_ctrl;
    logic [7:0]  af_hi;
    logic [7:0]  af_lo;
    logic [2:0]  code_lo;
    logic [7:0]  code_hi;
    logic [3:0]  fault_pol;
    logic [4:0]  flags;
    blc_sd_t     sd;
    logic [10:0] pwm_code;
    logic [10:0] ramp;
    logic [19:0] ramp_cnt;
    logic [10:0] led_code;
    logic [1:0]  af_sel;
    logic        dev_on;
    logic [7:0]  rdata;
    logic        rvalid;
  } blc_bank_t;

  localparam blc_bank_t BANK_RST = '{
    brt_ctrl:   RST_BRT_CTRL,
    pwm_ctrl:   RST_PWM_CTRL,
    boost_ctrl: RST_BOOST_CTRL,
    af_hi:      RST_AF,
    af_lo:      RST_AF,
    code_lo:    RST_CODE_LO,
    code_hi:    RST_CODE_HI,
    fault_pol:  RST_FAULT_POL,
    flags:      5'h00,
    sd:         SD_RUN,
    pwm_code:   11'h000,
    ramp:       11'h000,
    ramp_cnt:   20'h00000,
    led_code:   11'h000,
    af_sel:     AF_250K,
    dev_on:     1'b0,
    rdata:      8'h00,
    rvalid:     1'b0
  };

  blc_bank_t   st_r;
  blc_bank_t   st_nxt;
  logic [10:0] duty;
  logic        duty_valid;
  logic [10:0] reg_code;
  logic [10:0] target_code;
  logic [10:0] final_code;
  logic [10:0] dlt;
  logic [2:0]  hyst;
  logic [19:0] step_len;
  logic        step_due;
  logic [4:0]  evt;
  logic        trip;
  logic        fault_rd;
  logic [1:0]  src;

  // ----------------------------------------------------------------
  // PWM input conditioning
  // ----------------------------------------------------------------
  blc_pwm_sense u_sense (
    .i_sys_clk    (i_sys_clk),
    .i_resetn     (i_resetn),
    .i_clk_en     (i_clk_en),
    .i_pwm_pin    (i_pwm_pin),
    .i_rate_sel   (st_r.pwm_ctrl[PWM_RATE_LSB +: 2]),
    .i_pol_high   (st_r.pwm_ctrl[PWM_POL_BIT]),
    .i_filt_sel   (st_r.pwm_ctrl[PWM_FILT_LSB +: 2]),
    .o_duty       (duty),
    .o_duty_valid (duty_valid)
  );

  // ----------------------------------------------------------------
  // Arithmetic helpers
  // ----------------------------------------------------------------
  function automatic logic [10:0] scale(input logic [10:0] a, input logic [10:0] b);
    logic [22:0] p;
    p     = 23'(a) * (23'(b) + 23'd1);
    scale = p[21:11];
  endfunction

  function automatic logic [10:0] exp_map(input logic [10:0] c);
    logic [22:0] s;
    s       = 23'({1'b1, c[6:0]}) << c[10:7];
    exp_map = s[22:12];
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = 1'b0;
    src           = st_r.brt_ctrl[BRT_SRC_LSB +: 2];
    reg_code      = {st_r.code_hi, st_r.code_lo};
    fault_rd      = i_reg_rd && (i_reg_addr == ADDR_FAULT_IND);

    // Register writes
    if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_BRT_CTRL:   st_nxt.brt_ctrl   = i_reg_wdata & BRT_WMASK;
        ADDR_PWM_CTRL:   st_nxt.pwm_ctrl   = i_reg_wdata;
        ADDR_BOOST_CTRL: st_nxt.boost_ctrl = i_reg_wdata & BOOST_WMASK;
        ADDR_AF_HI:      st_nxt.af_hi      = i_reg_wdata;
        ADDR_AF_LO:      st_nxt.af_lo      = i_reg_wdata;
        ADDR_CODE_LO:    st_nxt.code_lo    = i_reg_wdata[2:0];
        ADDR_CODE_HI:    st_nxt.code_hi    = i_reg_wdata;
        ADDR_FAULT_POL:  st_nxt.fault_pol  = i_reg_wdata[3:0];
        default:         st_nxt.rdata      = st_r.rdata;
      endcase
    end

    // Register reads, one cycle latency, reserved and unmapped read zero
    if (i_reg_rd) begin
      st_nxt.rvalid = 1'b1;
      case (i_reg_addr)
        ADDR_BRT_CTRL:   st_nxt.rdata = st_r.brt_ctrl;
        ADDR_PWM_CTRL:   st_nxt.rdata = st_r.pwm_ctrl;
        ADDR_BOOST_CTRL: st_nxt.rdata = st_r.boost_ctrl;
        ADDR_AF_HI:      st_nxt.rdata = st_r.af_hi;
        ADDR_AF_LO:      st_nxt.rdata = st_r.af_lo;
        ADDR_CODE_LO:    st_nxt.rdata = {5'h00, st_r.code_lo};
        ADDR_CODE_HI:    st_nxt.rdata = st_r.code_hi;
        ADDR_FAULT_POL:  st_nxt.rdata = {4'h0, st_r.fault_pol};
        ADDR_FAULT_IND:  st_nxt.rdata = {3'h0, st_r.flags};
        default:         st_nxt.rdata = 8'h00;
      endcase
    end

    // Fault flags: a read clears, a fault present in the same cycle wins
    evt             = 5'h00;
    evt[FLAG_OPEN]  = i_string_open;
    evt[FLAG_SHORT] = i_string_short && st_r.fault_pol[POL_SHORT_EN];
    evt[FLAG_THERM] = i_thermal_trip;
    evt[FLAG_OCP]   = i_switch_current_limit;
    evt[FLAG_OVP]   = i_output_overvoltage_guard;
    st_nxt.flags    = (st_r.flags & ~{5{fault_rd}}) | evt;

    // Shutdown policy
    trip = (evt[FLAG_THERM] && !st_r.fault_pol[POL_THERM_BIT])
        || (evt[FLAG_OCP] && !st_r.fault_pol[POL_OCP_BIT])
        || ((evt[FLAG_OVP] || evt[FLAG_OPEN]) && !st_r.fault_pol[POL_OVP_BIT]);
    case (st_r.sd)
      SD_RUN: begin
        if (trip) begin
          st_nxt.sd = SD_WAIT_READ;
        end
      end
      SD_WAIT_READ: begin
        if (fault_rd && !trip) begin
          st_nxt.sd = SD_READY;
        end
      end
      SD_READY: begin
        if (trip) begin
          st_nxt.sd = SD_WAIT_READ;
        end else if (!i_dev_enable) begin
          st_nxt.sd = SD_RUN;
        end
      end
      default: st_nxt.sd = SD_RUN;
    endcase
    st_nxt.dev_on = i_dev_enable && (st_nxt.sd == SD_RUN);

    // PWM code with hysteresis
    hyst = st_r.pwm_ctrl[PWM_HYST_LSB +: 3];
    if (hyst == HYST_INVALID) begin
      hyst = HYST_RST;
    end
    dlt = (duty >= st_r.pwm_code) ? (duty - st_r.pwm_code) : (st_r.pwm_code - duty);
    if (duty_valid && (dlt != 11'h000) && (dlt >= {8'h00, hyst})) begin
      st_nxt.pwm_code = duty;
    end

    // Source selection feeding the ramp
    case (src)
      SRC_REG:      target_code = reg_code;
      SRC_PWM:      target_code = st_r.pwm_code;
      SRC_MUL_RAMP: target_code = scale(reg_code, st_r.pwm_code);
      default:      target_code = reg_code;
    endcase

    // Ramp: one code step per step period
    step_len = 20'(P_RAMP_BASE_CYC) << st_r.brt_ctrl[BRT_RATE_LSB +: 3];
    step_due = 1'b0;
    if (!st_r.brt_ctrl[BRT_RAMP_BIT]) begin
      st_nxt.ramp     = target_code;
      st_nxt.ramp_cnt = 20'h00000;
    end else if (st_r.ramp_cnt >= (step_len - 20'h00001)) begin
      st_nxt.ramp_cnt = 20'h00000;
      step_due        = st_r.ramp != target_code;
      if (st_r.ramp < target_code) begin
        st_nxt.ramp = st_r.ramp + 11'h001;
      end else if (st_r.ramp > target_code) begin
        st_nxt.ramp = st_r.ramp - 11'h001;
      end
    end else begin
      st_nxt.ramp_cnt = st_r.ramp_cnt + 20'h00001;
    end

    final_code      = (src == SRC_RAMP_MUL) ? scale(st_r.ramp, st_r.pwm_code) : st_r.ramp;
    st_nxt.led_code = st_r.brt_ctrl[BRT_MAP_BIT] ? exp_map(final_code) : final_code;

    // Auto frequency from the upper eight code bits
    if (final_code[10:3] > st_r.af_hi) begin
      st_nxt.af_sel = AF_1M;
    end else if (final_code[10:3] > st_r.af_lo) begin
      st_nxt.af_sel = AF_500K;
    end else begin
      st_nxt.af_sel = AF_250K;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      st_r <= BANK_RST;
    end else if (i_clk_en) begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_reg_rdata                    = st_r.rdata;
  assign o_reg_rvalid                   = st_r.rvalid;
  assign o_led_code                     = st_r.led_code;
  assign o_boost_freq_1m                = st_r.boost_ctrl[BST_FREQ_BIT];
  assign o_boost_no_shift               = st_r.boost_ctrl[BST_SHIFT_BIT];
  assign o_inductor_10u                 = st_r.boost_ctrl[BST_IND_BIT];
  assign o_output_overvoltage_guard_sel = st_r.boost_ctrl[BST_OVP_LSB +: 2];
  assign o_switch_current_limit_sel     = st_r.boost_ctrl[BST_OCP_LSB +: 2];
  assign o_autofreq_sel                 = st_r.af_sel;
  assign o_short_detect_on              = st_r.fault_pol[POL_SHORT_EN];
  assign o_device_on                    = st_r.dev_on;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  sequence trip_s;
    i_clk_en && trip && (st_r.sd == SD_RUN);
  endsequence

  sequence read_s;
    i_clk_en && fault_rd && !trip && (st_r.sd == SD_WAIT_READ);
  endsequence

  sequence ramp_due_s;
    i_clk_en && step_due;
  endsequence

  flag_set_a: assert property ((i_clk_en && i_thermal_trip) |=> st_r.flags[FLAG_THERM])
    else $error("thermal flag not set");
  flag_clear_a: assert property ((i_clk_en && fault_rd && !(|evt)) |=> !(|st_r.flags))
    else $error("fault read did not clear flags");
  short_gate_a: assert property (
    (i_clk_en && !st_r.fault_pol[POL_SHORT_EN] && !st_r.flags[FLAG_SHORT])
      |=> !st_r.flags[FLAG_SHORT])
    else $error("short flag set while detection disabled");
  shutdown_entry_a: assert property (trip_s |=> (st_r.sd == SD_WAIT_READ) && !o_device_on)
    else $error("fault did not force shutdown");
  report_only_a: assert property (
    (i_clk_en && st_r.sd == SD_RUN && st_r.fault_pol[2:0] == 3'h7) |=> st_r.sd == SD_RUN)
    else $error("report-only fault caused shutdown");
  reenable_block_a: assert property (
    (i_clk_en && st_r.sd == SD_WAIT_READ && !fault_rd) |=> !o_device_on)
    else $error("device re-enabled before fault read");
  read_release_a: assert property (read_s |=> st_r.sd == SD_READY)
    else $error("fault read did not release shutdown");
  reserved_zero_a: assert property ((i_clk_en && i_reg_rd && i_reg_addr == ADDR_CODE_LO)
    |=> o_reg_rvalid && o_reg_rdata[7:3] == 5'h00)
    else $error("reserved bits read nonzero");
  code_write_a: assert property ((i_clk_en && i_reg_wr && i_reg_addr == ADDR_CODE_HI)
    |=> st_r.code_hi == $past(i_reg_wdata))
    else $error("high code write lost");
  direct_code_a: assert property (
    (i_clk_en && src == SRC_REG && !st_r.brt_ctrl[BRT_RAMP_BIT] && !st_r.brt_ctrl[BRT_MAP_BIT]
      && !i_reg_wr) ##1 i_clk_en |=> o_led_code == $past(reg_code, 2))
    else $error("linear direct code not applied");
  ramp_step_a: assert property (
    ramp_due_s |=> (st_r.ramp == $past(st_r.ramp) + 11'h001)
                || (st_r.ramp == $past(st_r.ramp) - 11'h001))
    else $error("ramp did not move one step");
  autofreq_hi_a: assert property (
    (i_clk_en && final_code[10:3] > st_r.af_hi) |=> o_autofreq_sel == AF_1M)
    else $error("auto frequency not raised");

endmodule

// ### testbench/blc_host_model.sv
module blc_host_model (
  // Clock
  input  wire logic       i_sys_clk,
  // Register port
  output logic            o_reg_wr,
  output logic            o_reg_rd,
  output logic      [7:0] o_reg_addr,
  output logic      [7:0] o_reg_wdata,
  input  wire logic [7:0] i_reg_rdata,
  input  wire logic       i_reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
    o_reg_addr  = 8'h00;
    o_reg_wdata = 8'h00;
  end
  // Strobes live for one cycle; stale write data is inverted
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    o_reg_wr    = 1'b1;
    o_reg_addr  = a;
    o_reg_wdata = d;
    @(negedge i_sys_clk);
    o_reg_wr    = 1'b0;
    o_reg_wdata = ~d;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge i_sys_clk);
    o_reg_rd   = 1'b1;
    o_reg_addr = a;
    @(negedge i_sys_clk);
    o_reg_rd = 1'b0;
    d        = i_reg_rdata;
    v        = i_reg_rvalid;
  endtask
endmodule

// ### testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import blc_pkg::*;
  logic        i_sys_clk, i_resetn, i_dev_enable, wr, rd, rv, fm, ns, ind, sd, don, pwm, cen;
  logic [4:0]  flt;
  logic [7:0]  addr, wdat, rdat;
  logic [10:0] code;
  logic [1:0]  output_overvoltage_guard, switch_current_limit, af;
  int          num_errors, check_count, cycles, n;
  logic [7:0]  ra[9] = '{8'h11, 8'h12, 8'h13, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1e, 8'h1f};
  logic [7:0]  rv0[9] = '{8'h60, 8'hf3, 8'h6f, 8'h00, 8'h00, 8'h07, 8'hff, 8'h07, 8'h00};
  logic [7:0]  wa[10] = '{8'h11, 8'h12, 8'h13, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1e, 8'h1f, 8'h14};
  logic [7:0]  wd[10] = '{8'hff, 8'ha5, 8'h92, 8'h10, 8'h08, 8'hff, 8'h5a, 8'hff, 8'hff, 8'hff};
  logic [7:0]  we[10] = '{8'hfe, 8'ha5, 8'h12, 8'h10, 8'h08, 8'h07, 8'h5a, 8'h0f, 8'h00, 8'h00};
  blc_host_model host (.i_sys_clk(i_sys_clk), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr),
    .o_reg_wdata(wdat), .i_reg_rdata(rdat), .i_reg_rvalid(rv));
  blc_reg_bank #(.P_RAMP_BASE_CYC(4)) DUT (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_clk_en(cen), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdat),
    .o_reg_rdata(rdat), .o_reg_rvalid(rv), .i_pwm_pin(pwm), .i_dev_enable(i_dev_enable),
    .i_string_open(flt[4]), .i_string_short(flt[3]), .i_thermal_trip(flt[2]),
    .i_switch_current_limit(flt[1]), .i_output_overvoltage_guard(flt[0]), .o_led_code(code),
    .o_boost_freq_1m(fm), .o_boost_no_shift(ns), .o_inductor_10u(ind),
    .o_output_overvoltage_guard_sel(output_overvoltage_guard), .o_switch_current_limit_sel(switch_current_limit),
    .o_autofreq_sel(af), .o_short_detect_on(sd), .o_device_on(don));
  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  always #10 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 25000) begin
      num_errors++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [10:0] e, input logic [10:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    host.read_reg(a, d, v);
    chk("rvalid", 11'h1, {10'h0, v});
    chk($sformatf("reg %h", a), {3'h0, e}, {3'h0, d});
  endtask
  task automatic pulse(input logic [4:0] f);
    @(negedge i_sys_clk);
    flt = f;
    @(negedge i_sys_clk);
    flt = 5'h00;
    repeat (2) @(negedge i_sys_clk);
  endtask
  // Waits for a code value, at most lim cycles
  task automatic wait_code(input logic [10:0] c, input int lim);
    n = 0;
    while (code !== c && n < lim) begin
      @(negedge i_sys_clk);
      n++;
    end
  endtask
  task automatic toggle_en();
    i_dev_enable = 1'b0;
    repeat (3) @(negedge i_sys_clk);
    i_dev_enable = 1'b1;
    repeat (3) @(negedge i_sys_clk);
  endtask
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    i_sys_clk    = 1'b0;
    i_resetn     = 1'b0;
    i_dev_enable = 1'b1;
    flt          = 5'h00;
    cen          = 1'b1;
    pwm          = 1'b0;
    repeat (20) @(negedge i_sys_clk);
    i_resetn = 1'b1;
    chk("ctl", 11'h0de, {3'h0, fm, ns, ind, output_overvoltage_guard, switch_current_limit, sd});
    for (int i = 0; i < 9; i++) chk_reg(ra[i], rv0[i]);
    for (int i = 0; i < 10; i++) host.write_reg(wa[i], wd[i]);
    for (int i = 0; i < 10; i++) chk_reg(wa[i], we[i]);
    chk("ctl", 11'h025, {3'h0, fm, ns, ind, output_overvoltage_guard, switch_current_limit, sd});
    cen = 1'b0;
    host.write_reg(8'h15, 8'h77);
    cen = 1'b1;
    chk_reg(8'h15, 8'h10);
    host.write_reg(8'h11, 8'h00);
    host.write_reg(8'h19, 8'h12);
    host.write_reg(8'h18, 8'h05);
    repeat (4) @(negedge i_sys_clk);
    chk("code", 11'h095, code);
    chk("afreq", {9'h0, AF_1M}, {9'h0, af});
    host.write_reg(8'h19, 8'h0c);
    repeat (4) @(negedge i_sys_clk);
    chk("afreq", {9'h0, AF_500K}, {9'h0, af});
    host.write_reg(8'h19, 8'h08);
    repeat (4) @(negedge i_sys_clk);
    chk("afreq", {9'h0, AF_250K}, {9'h0, af});
    host.write_reg(8'h19, 8'hff);
    host.write_reg(8'h18, 8'h07);
    host.write_reg(8'h11, 8'h80);
    repeat (4) @(negedge i_sys_clk);
    chk("code", 11'h7f8, code);
    host.write_reg(8'h11, 8'h10);
    host.write_reg(8'h18, 8'h05);
    wait_code(11'h7fd, 40);
    chk("ramp", 11'h1, {10'h0, n >= 4 && n < 40});
    host.write_reg(8'h1e, 8'h07);
    pulse(5'h08);
    chk_reg(8'h1f, 8'h00);
    host.write_reg(8'h1e, 8'h0b);
    pulse(5'h19);
    chk("on", 11'h1, {10'h0, don});
    chk_reg(8'h1f, 8'h19);
    chk_reg(8'h1f, 8'h00);
    pulse(5'h04);
    chk("on", 11'h0, {10'h0, don});
    toggle_en();
    chk("on", 11'h0, {10'h0, don});
    chk_reg(8'h1f, 8'h04);
    chk("on", 11'h0, {10'h0, don});
    toggle_en();
    chk("on", 11'h1, {10'h0, don});
    host.write_reg(8'h11, 8'h20);
    repeat (4) @(negedge i_sys_clk);
    chk("src", 11'h000, code);
    pwm = 1'b1;
    wait_code(11'h7ff, 9000);
    chk("pwm", 11'h7ff, code);
    host.write_reg(8'h12, 8'h85);
    wait_code(11'h000, 9000);
    chk("pol", 11'h000, code);
    results();
  end
endmodule
